// ---- dv/comparator_status_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module comparator_status_control_tb;
	import csc_pkg::*;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, slow = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, cmp_raw, cmp_enable, cmp_ref_select, irq;
	logic comparator_output_pin, comparator_output_pin_oe;
	logic [8:0] q[$];
	csc_byte_t rnd = 8'h1d, c;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	csc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
		.cmp_ref_select(cmp_ref_select), .comparator_output_pin(comparator_output_pin),
		.comparator_output_pin_oe(comparator_output_pin_oe), .irq(irq));
	csc_cmp_model core (.sys_clk(sys_clk), .powered(cmp_enable), .lvl(lvl), .slow(slow),
		.cmp_raw(cmp_raw));
	function automatic csc_byte_t lfsr(input csc_byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// apb transfer; a read notes its expected {pslverr, data}
	task automatic xfer(input logic w, input logic [11:0] a, input csc_byte_t d,
		input logic [8:0] e);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		if (!w) q.push_back(e);
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (!pready);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic settle;
		repeat (8) @(posedge sys_clk);
	endtask
	// read monitor takes the oldest note
	always @(posedge sys_clk)
		if (psel && penable && pready && !pwrite && q.size() > 0)
			chk("read", {pslverr, prdata[7:0]}, q.pop_front());
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1;
		xfer(0, 12'h000, 0, 9'h000);
		xfer(0, 12'h008, 0, 9'h020);
		// every mode code, falling then rising edge
		for (int m = 0; m < 4; m++) begin
			rnd = lfsr(rnd);
			c = 8'h80 | 8'(m) | {1'b0, rnd[0], 6'h0};
			slow <= rnd[1];
			lvl <= 1;
			xfer(1, 12'h000, c, 0);
			settle();
			xfer(1, 12'h000, c | 8'h20, 0);
			xfer(0, 12'h000, 0, {1'b0, c | 8'h08});
			chk("en_ref", {cmp_enable, cmp_ref_select}, {1'b1, rnd[0]});
			lvl <= 0;
			settle();
			xfer(0, 12'h000, 0, {1'b0, c | (m != 1 ? 8'h20 : 8'h00)});
			xfer(1, 12'h000, c | 8'h20, 0);
			lvl <= 1;
			settle();
			xfer(0, 12'h000, 0, {1'b0, c | 8'h28 & (m[0] ? 8'hff : 8'h08)});
		end
		$display("test modes done");
		xfer(1, 12'h000, 8'h93, 0);
		xfer(0, 12'h000, 0, 9'h0bb);
		chk("irq", irq, 1);
		xfer(1, 12'h000, 8'h83, 0);
		@(posedge sys_clk);
		chk("irq", irq, 0);
		xfer(1, 12'h008, 8'h00, 0);
		xfer(1, 12'h000, 8'h93, 0);
		@(posedge sys_clk);
		chk("irq", irq, 0);
		xfer(1, 12'h008, 8'h20, 0);
		@(posedge sys_clk);
		chk("irq", irq, 1);
		xfer(0, 12'h004, 0, 9'h020);
		xfer(1, 12'h00c, 8'h20, 0);
		@(posedge sys_clk);
		chk("irq", irq, 0);
		xfer(0, 12'h004, 0, 9'h000);
		xfer(0, 12'h010, 0, 9'h100);
		$display("test interrupt done");
		xfer(1, 12'h000, 8'h84, 0);
		settle();
		chk("pin", {comparator_output_pin_oe, comparator_output_pin}, 2'b11);
		xfer(1, 12'h000, 8'h80, 0);
		@(posedge sys_clk);
		chk("pin", {comparator_output_pin_oe, comparator_output_pin}, 2'b00);
		xfer(1, 12'h000, 8'h09, 0);
		settle();
		xfer(0, 12'h000, 0, 9'h001);
		chk("off", {cmp_enable, comparator_output_pin}, 2'b00);
		$display("test pin done");
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- dv/csc_cmp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// analog core stand-in: live level, or a two-cycle lag when slow
module csc_cmp_model (
	// control
	input  wire logic sys_clk,
	input  wire logic powered,
	input  wire logic lvl,
	input  wire logic slow,
	// output
	output logic      cmp_raw
);
	logic [1:0] lag;
	always @(posedge sys_clk) lag <= {lag[0], lvl};
	// a core that is switched off sits low
	assign cmp_raw = powered ? (slow ? lag[1] : lvl) : 1'b0;
endmodule
`default_nettype wire

// ---- rtl/csc_map.svh ----
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
// register byte offsets
`define CSC_OFF_CTRL      12'h000
`define CSC_OFF_INT_STAT  12'h004
`define CSC_OFF_INT_EN    12'h008
`define CSC_OFF_INT_CLR   12'h00C
// field positions of the status and control register
`define CSC_BIT_ENABLE    7
`define CSC_BIT_REFSEL    6
`define CSC_BIT_FLAG      5
`define CSC_BIT_IE        4
`define CSC_BIT_OUT       3
`define CSC_BIT_PINEN     2
`define CSC_MOD_HI        1
`define CSC_MOD_LO        0
// reset values
`define CSC_CTRL_RESET    8'h00
`define CSC_INT_EN_RESET  1'b1
// mode codes
`define CSC_MODE_FALL0    2'h0
`define CSC_MODE_RISE     2'h1
`define CSC_MODE_FALL2    2'h2
`define CSC_MODE_BOTH     2'h3
`endif

// ---- rtl/csc_pkg.sv ----
package csc_pkg;
	typedef logic [1:0] csc_mode_t;
	typedef logic [7:0] csc_byte_t;
endpackage

// ---- rtl/csc_top.sv ----
// Contract
// - the comparator is enabled only while control bit 7 is one.
// - bit 6 clear selects the external positive input pin, set selects the bandgap reference.
// - bit 5 is set whenever the compare event chosen by the mode field is detected.
// - bit 5 is cleared only by writing one to it or to bit 5 of the clear register; writing zero leaves it alone.
// - with bit 4 and the interrupt enable register bit 5 both set the interrupt request is asserted while the flag is set, else never.
// - bit 3 reads the present comparator output level and is read-only.
// - while the enable bit is zero, bit 3 is forced to zero and reads zero.
// - bit 2 set drives the comparator output onto the output pin, clear keeps it off.
// - mode codes 00 and 10 pick falling, 01 rising, 11 either edge.
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module csc_top #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// analog core
	input  wire logic              cmp_raw,
	output logic                   cmp_enable,
	output logic                   cmp_ref_select,
	// pin and interrupt
	output logic                   comparator_output_pin,
	output logic                   comparator_output_pin_oe,
	output logic                   irq
);
	import csc_pkg::*;

	initial begin
		if (ADDR_W < 4) $error("ADDR_W too small");
	end

	// register state
	csc_byte_t   ctrl_r, ctrl_nxt;
	logic        flag_r, flag_nxt;
	logic        ien_r, ien_nxt;
	logic        sync1_r, sync2_r, prev_r;
	logic        sync_nxt, prev_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_r, pslverr_nxt;

	logic wr, rd, edge_hit, mode_fall, mode_rise, live_out;
	logic clr_flag;
	csc_mode_t mode;

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		addr_is = (a == ADDR_W'(off));
	endfunction

	// true for any of the four register offsets
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = addr_is(a, `CSC_OFF_CTRL) || addr_is(a, `CSC_OFF_INT_STAT) ||
			addr_is(a, `CSC_OFF_INT_EN) || addr_is(a, `CSC_OFF_INT_CLR);
	endfunction

	// apb strobes, zero wait state
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// control outputs to the analog core
	assign cmp_enable     = ctrl_r[`CSC_BIT_ENABLE];
	assign cmp_ref_select = ctrl_r[`CSC_BIT_REFSEL];
	assign mode = ctrl_r[`CSC_MOD_HI:`CSC_MOD_LO];

	// live output forced low while disabled
	assign live_out = sync2_r && cmp_enable;

	// edge detect against previous synchronised sample
	always_comb begin
		mode_rise = (mode == `CSC_MODE_RISE) || (mode == `CSC_MODE_BOTH);
		mode_fall = (mode == `CSC_MODE_FALL0) || (mode == `CSC_MODE_FALL2) ||
			(mode == `CSC_MODE_BOTH);
		edge_hit = cmp_enable && ((mode_rise && live_out && !prev_r) ||
			(mode_fall && !live_out && prev_r));
	end

	// synchroniser next values
	always_comb begin
		sync_nxt = cmp_raw;
		prev_nxt = live_out;
	end

	// two stage synchroniser and edge history
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= sync_nxt;
			sync2_r <= sync1_r;
			prev_r  <= prev_nxt;
		end
	end

	// register writes, flag set beats clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		ien_nxt  = ien_r;
		clr_flag = 1'b0;
		if (wr && pstrb[0]) begin
			if (addr_is(paddr, `CSC_OFF_CTRL)) begin
				ctrl_nxt = pwdata[7:0];
				clr_flag = pwdata[`CSC_BIT_FLAG];
			end else if (addr_is(paddr, `CSC_OFF_INT_EN)) begin
				ien_nxt = pwdata[`CSC_BIT_FLAG];
			end else if (addr_is(paddr, `CSC_OFF_INT_CLR)) begin
				clr_flag = pwdata[`CSC_BIT_FLAG];
			end
		end
		ctrl_nxt[`CSC_BIT_FLAG] = 1'b0;
		ctrl_nxt[`CSC_BIT_OUT]  = 1'b0;
		if (edge_hit) begin
			flag_nxt = 1'b1;
		end else if (clr_flag) begin
			flag_nxt = 1'b0;
		end else begin
			flag_nxt = flag_r;
		end
	end

	// read mux and error answer
	always_comb begin
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (addr_is(paddr, `CSC_OFF_CTRL)) begin
				prdata_nxt[7:0] = ctrl_r;
				prdata_nxt[`CSC_BIT_FLAG] = flag_r;
				prdata_nxt[`CSC_BIT_OUT]  = live_out;
			end else if (addr_is(paddr, `CSC_OFF_INT_STAT)) begin
				prdata_nxt[`CSC_BIT_FLAG] = flag_r;
			end else if (addr_is(paddr, `CSC_OFF_INT_EN)) begin
				prdata_nxt[`CSC_BIT_FLAG] = ien_r;
			end
		end
		// error decided in setup so that it stands through the access phase
		if (psel && !penable && !addr_mapped(paddr)) begin
			pslverr_nxt = 1'b1;
		end
		if (psel && !penable && !pwrite && addr_is(paddr, `CSC_OFF_INT_CLR)) begin
			pslverr_nxt = 1'b1;  // clear register is write-only
		end
	end

	// register state flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r    <= `CSC_CTRL_RESET;
			flag_r    <= 1'b0;
			ien_r     <= `CSC_INT_EN_RESET;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			flag_r    <= flag_nxt;
			ien_r     <= ien_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// interrupt needs the control bit and the enable register both
	assign irq = flag_r && ctrl_r[`CSC_BIT_IE] && ien_r;

	// output pin drive
	assign comparator_output_pin    = live_out && ctrl_r[`CSC_BIT_PINEN];
	assign comparator_output_pin_oe = ctrl_r[`CSC_BIT_PINEN];

	// edge sequences for checks
	sequence s_rise;
		$rose(live_out);
	endsequence
	sequence s_fall;
		$fell(live_out);
	endsequence
	// falling edge while the comparator stays on
	sequence s_enabled_fall;
		cmp_enable && !live_out && prev_r;
	endsequence
	// software write to the control register
	sequence s_ctrl_write;
		wr && pstrb[0] && addr_is(paddr, `CSC_OFF_CTRL);
	endsequence

	// core enable follows bit 7
	chk_enable_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmp_enable == ctrl_r[`CSC_BIT_ENABLE]) else $error("enable mismatch");

	// reference select follows bit 6
	chk_ref_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmp_ref_select == ctrl_r[`CSC_BIT_REFSEL]) else $error("ref select mismatch");

	// rising edge in a rising mode sets the flag
	chk_rise_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_rise and mode_rise and cmp_enable) |=> flag_r) else $error("rise lost");

	// falling edge in a falling mode sets the flag; switching off is no edge
	chk_fall_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_fall and mode_fall and cmp_enable) |=> flag_r) else $error("fall lost");

	// flag only drops on a clear
	chk_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flag_r && !clr_flag) |=> flag_r) else $error("flag dropped");

	// interrupt level from flag and both enables
	chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		irq == (flag_r && ctrl_r[`CSC_BIT_IE] && ien_r)) else $error("irq wrong");

	// live output is low while switched off
	chk_out_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!cmp_enable |-> !live_out) else $error("output not forced low");

	// two flop latency of the synchroniser
	chk_sync_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmp_enable && $past(cmp_enable, 2) |-> sync2_r == $past(cmp_raw, 2))
		else $error("sync latency wrong");

	// pin low while its enable is clear
	chk_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctrl_r[`CSC_BIT_PINEN] |-> !comparator_output_pin) else $error("pin driven");

	// read data bit 3 carries the live level of the setup cycle
	chk_read_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && addr_is(paddr, `CSC_OFF_CTRL)) |=>
		prdata[`CSC_BIT_OUT] == $past(live_out)) else $error("out bit read wrong");

	// any detected event leaves the flag set, even against a clear
	chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
		edge_hit |=> flag_r) else $error("event lost against clear");

	// no event, no flag
	chk_no_spurious: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!flag_r && !edge_hit) |=> !flag_r) else $error("flag set without event");

	// writing one to bit 5 of control clears the flag
	chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_ctrl_write and pwdata[`CSC_BIT_FLAG] and !edge_hit) |=> !flag_r)
		else $error("flag not cleared");

	// writing zero to bit 5 of control keeps the flag
	chk_write_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_ctrl_write and !pwdata[`CSC_BIT_FLAG] and flag_r) |=> flag_r)
		else $error("flag lost on zero write");

	// interrupt stays low while bit 4 is clear
	chk_irq_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctrl_r[`CSC_BIT_IE] |-> !irq) else $error("irq without enable");

	// flag and live bits are never stored in the control register
	chk_ro_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctrl_r[`CSC_BIT_FLAG] && !ctrl_r[`CSC_BIT_OUT]) else $error("status bit stored");

	// pin follows the live level while enabled
	chk_pin_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl_r[`CSC_BIT_PINEN] |-> (comparator_output_pin == live_out) &&
		comparator_output_pin_oe) else $error("pin not following");

	// code 10 also picks falling edges
	chk_mode_fall2: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_enabled_fall and (mode == `CSC_MODE_FALL2)) |=> flag_r)
		else $error("mode two fall lost");

	// code 00 ignores rising edges
	chk_rise_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode == `CSC_MODE_FALL0 && live_out && !prev_r && !flag_r) |=> !flag_r)
		else $error("rise flagged in fall mode");

	// edge history is the last live sample
	chk_prev_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prev_r == $past(live_out)) else $error("edge history stale");

	// status register read returns the flag
	chk_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && addr_is(paddr, `CSC_OFF_INT_STAT)) |=>
		prdata[`CSC_BIT_FLAG] == $past(flag_r)) else $error("status read wrong");

	// unmapped address answers with an error in the access phase
	chk_err_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !addr_mapped(paddr)) |=> pslverr) else $error("no error");

	// reading the clear register is refused
	chk_clr_noread: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd && addr_is(paddr, `CSC_OFF_INT_CLR)) |-> pslverr) else $error("clear read taken");
endmodule
`default_nettype wire
